//--- src/speed_alarm_relay_control.sv
/*
 * Speed alarm and calibration weight lifter relay controller with its
 * AHB-Lite register slave and interrupt logic.
 * Assumes one 250 MHz clock, an asynchronous active-low reset, and a
 * function button and span step inputs that arrive from outside.
 */
`timescale 1ns/100ps
`default_nettype none

module speed_alarm_relay_control #(
    parameter int unsigned TICK_CYCLES = relay_ctl_pkg::TENTH_CYCLES
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic haddr_sel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic function_button,
    input wire logic [1:0] span_step,
    output logic relay_contact,
    output logic program_mode,
    output logic setting_step,
    output logic [3:0] station_id,
    output logic [1:0] port_a_role,
    output logic [1:0] port_b_role,
    output logic [15:0] rate_gain,
    output logic irq
);

    relay_ctl_pkg::relay_state_t st;
    relay_ctl_pkg::relay_state_t nx;
    logic [1:0] rst_sync;
    logic rst_n;
    logic below;
    logic above;
    logic cond;
    logic [15:0] delay_cycles_tenths;
    logic tick;
    logic take;
    logic [7:0] ph_addr_now;

    default clocking sys_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // Reset released through two flip-flops
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    assign tick = (st.tick_cnt == 25'(TICK_CYCLES - 1));
    assign ph_addr_now = haddr[7:0];
    assign take = haddr_sel && hready && htrans[1];

    always_comb begin
        below = relay_ctl_pkg::bcd4_to_bin(st.speed)
            < relay_ctl_pkg::bcd4_to_bin(st.low_set);
        above = relay_ctl_pkg::bcd4_to_bin(st.speed)
            > relay_ctl_pkg::bcd4_to_bin(st.high_set);
        case (st.func)
            relay_ctl_pkg::FN_LOW_SPEED: cond = below;
            relay_ctl_pkg::FN_HIGH_SPEED: cond = above;
            relay_ctl_pkg::FN_BAND_SPEED: cond = below || above;
            default: cond = 1'b0;
        endcase
        cond = cond && st.enable;
        delay_cycles_tenths = 16'((st.delay_set[7:4] * 8'd10
            + st.delay_set[3:0]) * relay_ctl_pkg::TENTHS_PER_S);
    end

    always_comb begin
        nx = st;
        nx.button_sync = {st.button_sync[0], function_button};
        nx.span_a_sync = {st.span_a_sync[0], span_step[0]};
        nx.span_b_sync = {st.span_b_sync[0], span_step[1]};
        nx.prev_span = {st.span_b_sync[1], st.span_a_sync[1]};
        nx.tick_cnt = tick ? 25'h0 : st.tick_cnt + 25'h1;
        nx.setting_step = 1'b0;

        // Function button: long hold toggles mode, short press steps in program mode
        if (st.button_sync[1]) begin
            if (tick && !st.hold_done) begin
                if (st.hold_cnt == 8'(relay_ctl_pkg::HOLD_TENTHS - 1)) begin
                    nx.hold_done = 1'b1;
                    nx.program_mode = !st.program_mode;
                    nx.irq_stat[relay_ctl_pkg::IRQ_MODE] = 1'b1;
                    if (st.program_mode) begin
                        nx.sim_on = 1'b0;
                        if (st.sim_on) begin
                            nx.rate_gain = st.saved_gain;
                        end
                    end
                end else begin
                    nx.hold_cnt = st.hold_cnt + 8'h1;
                end
            end
        end else begin
            if (st.hold_cnt != 8'h0 && !st.hold_done && st.program_mode) begin
                nx.setting_step = 1'b1;
            end
            nx.hold_cnt = 8'h0;
            nx.hold_done = 1'b0;
        end

        // Operate delay counts tenths while the condition holds
        if (!cond) begin
            nx.delay_cnt = 16'h0;
            nx.alarm = 1'b0;
        end else if (st.delay_cnt >= delay_cycles_tenths) begin
            nx.alarm = 1'b1;
        end else if (tick) begin
            nx.delay_cnt = st.delay_cnt + 16'h1;
        end
        if (nx.alarm && !st.alarm) begin
            nx.irq_stat[relay_ctl_pkg::IRQ_ALARM_ON] = 1'b1;
        end
        if (!nx.alarm && st.alarm) begin
            nx.irq_stat[relay_ctl_pkg::IRQ_ALARM_OFF] = 1'b1;
        end

        // Span cycle steps drive the lifter
        nx.span = relay_ctl_pkg::span_step_t'({1'b0, st.prev_span});
        case (st.span)
            relay_ctl_pkg::SPAN_LOWER: nx.lifter_on = 1'b1;
            relay_ctl_pkg::SPAN_WAIT: nx.lifter_on = 1'b1;
            relay_ctl_pkg::SPAN_RAISE: nx.lifter_on = 1'b0;
            default: nx.lifter_on = st.lifter_on;
        endcase

        if (st.func == relay_ctl_pkg::FN_LIFTER && st.enable) begin
            nx.contact = st.lifter_on ^ st.closed_at_rest;
        end else if (st.enable && st.func != relay_ctl_pkg::FN_NONE) begin
            nx.contact = st.alarm ^ st.closed_at_rest;
        end else begin
            nx.contact = st.closed_at_rest;
        end

        // Bus data phase
        nx.ph_valid = take;
        nx.ph_write = hwrite;
        nx.ph_addr = ph_addr_now;
        nx.hrdata = 32'h0;
        if (take && !hwrite) begin
            if (ph_addr_now == relay_ctl_pkg::OFS_CTRL) begin
                nx.hrdata = {25'h0, st.func, 1'b0, st.sim_on,
                    st.closed_at_rest, st.enable};
            end else if (ph_addr_now == relay_ctl_pkg::OFS_LOW) begin
                nx.hrdata = {16'h0, st.low_set};
            end else if (ph_addr_now == relay_ctl_pkg::OFS_HIGH) begin
                nx.hrdata = {16'h0, st.high_set};
            end else if (ph_addr_now == relay_ctl_pkg::OFS_DELAY) begin
                nx.hrdata = {24'h0, st.delay_set};
            end else if (ph_addr_now == relay_ctl_pkg::OFS_SPEED) begin
                nx.hrdata = {16'h0, st.speed};
            end else if (ph_addr_now == relay_ctl_pkg::OFS_STATUS) begin
                nx.hrdata = {27'h0, st.lifter_on, st.program_mode,
                    cond, st.alarm, st.contact};
            end else if (ph_addr_now == relay_ctl_pkg::OFS_IRQ_STAT) begin
                nx.hrdata = {29'h0, st.irq_stat};
                // Read clears, but an event in this cycle survives
                nx.irq_stat = 3'h0;
                if (nx.alarm && !st.alarm) begin
                    nx.irq_stat[relay_ctl_pkg::IRQ_ALARM_ON] = 1'b1;
                end
                if (!nx.alarm && st.alarm) begin
                    nx.irq_stat[relay_ctl_pkg::IRQ_ALARM_OFF] = 1'b1;
                end
                if (nx.program_mode != st.program_mode) begin
                    nx.irq_stat[relay_ctl_pkg::IRQ_MODE] = 1'b1;
                end
            end else if (ph_addr_now == relay_ctl_pkg::OFS_IRQ_MASK) begin
                nx.hrdata = {29'h0, st.irq_mask};
            end else if (ph_addr_now == relay_ctl_pkg::OFS_SERIAL) begin
                nx.hrdata = {24'h0, st.serial};
            end else if (ph_addr_now == relay_ctl_pkg::OFS_GAIN) begin
                nx.hrdata = {16'h0, st.rate_gain};
            end
        end
        if (st.ph_valid && st.ph_write) begin
            // Thresholds are never rescaled here; software re-enters them
            if (st.ph_addr == relay_ctl_pkg::OFS_CTRL) begin
                nx.enable = hwdata[relay_ctl_pkg::CTRL_EN_BIT];
                nx.closed_at_rest = hwdata[relay_ctl_pkg::CTRL_POL_BIT];
                nx.func = relay_ctl_pkg::relay_fn_t'(
                    hwdata[relay_ctl_pkg::CTRL_FN_LSB +: 3]);
                if (hwdata[relay_ctl_pkg::CTRL_SIM_BIT] && !st.sim_on) begin
                    nx.saved_gain = st.rate_gain;
                end
                nx.sim_on = hwdata[relay_ctl_pkg::CTRL_SIM_BIT];
            end else if (st.ph_addr == relay_ctl_pkg::OFS_LOW) begin
                nx.low_set = hwdata[15:0];
            end else if (st.ph_addr == relay_ctl_pkg::OFS_HIGH) begin
                nx.high_set = hwdata[15:0];
            end else if (st.ph_addr == relay_ctl_pkg::OFS_DELAY) begin
                nx.delay_set = hwdata[7:0];
            end else if (st.ph_addr == relay_ctl_pkg::OFS_SPEED) begin
                nx.speed = hwdata[15:0];
            end else if (st.ph_addr == relay_ctl_pkg::OFS_IRQ_MASK) begin
                nx.irq_mask = hwdata[2:0];
            end else if (st.ph_addr == relay_ctl_pkg::OFS_SERIAL) begin
                nx.serial = hwdata[7:0];
            end else if (st.ph_addr == relay_ctl_pkg::OFS_GAIN) begin
                nx.rate_gain = hwdata[15:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.low_set <= relay_ctl_pkg::LOW_RESET;
            st.high_set <= relay_ctl_pkg::HIGH_RESET;
            st.delay_set <= relay_ctl_pkg::DELAY_RESET;
            st.serial.station_id <= relay_ctl_pkg::STATION_RESET;
        end else begin
            st <= nx;
        end
    end

    assign hrdata = st.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign relay_contact = st.contact;
    assign program_mode = st.program_mode;
    assign setting_step = st.setting_step;
    assign station_id = st.serial.station_id;
    assign port_a_role = st.serial.port_a_role;
    assign port_b_role = st.serial.port_b_role;
    assign rate_gain = st.rate_gain;
    assign irq = |(st.irq_stat & st.irq_mask);

    a_low_alarm_state: assert property (
        st.enable && st.func == relay_ctl_pkg::FN_LOW_SPEED && st.alarm
        |-> $past(below))
        else $error("low alarm without low speed");

    a_high_alarm_state: assert property (
        st.enable && st.func == relay_ctl_pkg::FN_HIGH_SPEED && st.alarm
        |-> $past(above))
        else $error("high alarm without high speed");

    a_band_alarm_state: assert property (
        st.enable && st.func == relay_ctl_pkg::FN_BAND_SPEED && st.alarm
        |-> $past(below || above))
        else $error("band alarm inside band");

    a_contact_polarity: assert property (
        st.enable && st.func == relay_ctl_pkg::FN_LOW_SPEED
        |=> st.contact == ($past(st.alarm) ^ $past(st.closed_at_rest)))
        else $error("contact polarity wrong");

    a_zero_delay_fast: assert property (
        cond && st.delay_set == 8'h00 |=> st.alarm || !$past(cond))
        else $error("zero delay not immediate");

    a_alarm_drops_clear: assert property (
        !cond |=> !st.alarm && st.delay_cnt == 16'h0)
        else $error("alarm not dropped");

    a_disabled_no_alarm: assert property (
        !st.enable [*2] |-> !st.alarm)
        else $error("alarm while disabled");

    sequence lifter_lowering;
        st.func == relay_ctl_pkg::FN_LIFTER && st.enable
            && !st.closed_at_rest && st.lifter_on;
    endsequence

    a_lifter_closes: assert property (
        lifter_lowering ##1 (st.func == relay_ctl_pkg::FN_LIFTER
            && st.enable && !st.closed_at_rest) |-> st.contact)
        else $error("lifter contact not closed");

    a_lifter_raise_open: assert property (
        st.span == relay_ctl_pkg::SPAN_RAISE |=> !st.lifter_on)
        else $error("lifter not released on raise");

    a_mode_needs_hold: assert property (
        st.program_mode != $past(st.program_mode) |-> $past(st.button_sync[1])
            && $past(st.hold_cnt) == 8'(relay_ctl_pkg::HOLD_TENTHS - 1))
        else $error("mode changed without long hold");

    a_sim_cleared_run: assert property (
        $fell(st.program_mode) |-> !st.sim_on)
        else $error("simulation left on in run mode");

    sequence serial_written;
        st.ph_valid && st.ph_write
            && st.ph_addr == relay_ctl_pkg::OFS_SERIAL;
    endsequence

    a_station_shared: assert property (
        serial_written |=> station_id == $past(hwdata[7:4]))
        else $error("station id not taken");

    a_port_roles_set: assert property (
        serial_written |=> {port_a_role, port_b_role} == $past(hwdata[3:0]))
        else $error("port roles not taken");

    a_low_set_held: assert property (
        !(st.ph_valid && st.ph_write) |=> $stable(st.low_set))
        else $error("lower threshold changed without write");

    a_high_set_held: assert property (
        !(st.ph_valid && st.ph_write) |=> $stable(st.high_set))
        else $error("upper threshold changed without write");

    a_delay_restart: assert property (
        cond && !$past(cond) |-> st.delay_cnt == 16'h0)
        else $error("delay not restarted");

    a_delay_before_alarm: assert property (
        $rose(st.alarm) |-> $past(st.delay_cnt) >= $past(delay_cycles_tenths))
        else $error("alarm before operate delay");

    a_band_shared_count: assert property (
        st.func == relay_ctl_pkg::FN_BAND_SPEED && cond && tick
            && st.delay_cnt < delay_cycles_tenths
            |=> st.delay_cnt == $past(st.delay_cnt) + 16'h1)
        else $error("band delay not counting");

    a_short_press_step: assert property (
        st.setting_step |-> $past(st.program_mode) && !$past(st.hold_done))
        else $error("setting step without short press");

    a_gain_restored: assert property (
        $fell(st.program_mode) && $past(st.sim_on)
            |-> st.rate_gain == $past(st.saved_gain))
        else $error("rate gain not restored");

    a_lifter_lower_on: assert property (
        st.span == relay_ctl_pkg::SPAN_LOWER |=> st.lifter_on)
        else $error("lifter not set while lowering");

    a_lifter_wait_on: assert property (
        st.span == relay_ctl_pkg::SPAN_WAIT |=> st.lifter_on)
        else $error("lifter released while waiting");

    a_lifter_idle_hold: assert property (
        st.span == relay_ctl_pkg::SPAN_IDLE |=> $stable(st.lifter_on))
        else $error("lifter moved while idle");

    a_disabled_rest: assert property (
        !st.enable |=> st.contact == $past(st.closed_at_rest))
        else $error("contact left rest while disabled");

endmodule
`default_nettype wire

//--- src/relay_ctl_pkg.sv
/*
 * Package for the speed alarm relay controller: register map, field
 * layouts, reset values, timing constants and carrier structs.
 * Assumes a single 250 MHz system clock and an AHB-Lite register bus.
 */
`default_nettype none
package relay_ctl_pkg;

    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned TENTH_MS = 100;
    localparam int unsigned TENTH_CYCLES = CLK_HZ / 1000 * TENTH_MS;
    localparam int unsigned HOLD_S = 5;
    localparam int unsigned HOLD_TENTHS = HOLD_S * 10;
    localparam int unsigned TENTHS_PER_S = 10;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LOW = 8'h04;
    localparam logic [7:0] OFS_HIGH = 8'h08;
    localparam logic [7:0] OFS_DELAY = 8'h0c;
    localparam logic [7:0] OFS_SPEED = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
    localparam logic [7:0] OFS_SERIAL = 8'h20;
    localparam logic [7:0] OFS_GAIN = 8'h24;

    localparam logic [15:0] LOW_RESET = 16'h0015;
    localparam logic [15:0] HIGH_RESET = 16'h0100;
    localparam logic [7:0] DELAY_RESET = 8'h00;
    localparam logic [3:0] STATION_RESET = 4'h0;
    localparam int unsigned MAX_STATIONS = 16;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_POL_BIT = 1;
    localparam int CTRL_SIM_BIT = 2;
    localparam int CTRL_FN_LSB = 4;

    localparam int unsigned IRQ_ALARM_ON = 0;
    localparam int unsigned IRQ_ALARM_OFF = 1;
    localparam int unsigned IRQ_MODE = 2;

    typedef enum logic [2:0] {
        FN_NONE = 3'h0,
        FN_LOW_SPEED = 3'h1,
        FN_HIGH_SPEED = 3'h2,
        FN_BAND_SPEED = 3'h3,
        FN_LIFTER = 3'h4
    } relay_fn_t;

    typedef enum logic [2:0] {
        SPAN_IDLE = 3'b000,
        SPAN_LOWER = 3'b001,
        SPAN_WAIT = 3'b011,
        SPAN_RAISE = 3'b010
    } span_step_t;

    typedef struct packed {
        logic [3:0] station_id;
        logic [1:0] port_a_role;
        logic [1:0] port_b_role;
    } serial_cfg_t;

    typedef struct packed {
        logic [1:0] resetn_sync;
        logic [1:0] button_sync;
        logic [1:0] span_a_sync;
        logic [1:0] span_b_sync;
        logic [1:0] prev_span;
        logic [31:0] hrdata;
        logic ph_valid;
        logic ph_write;
        logic [7:0] ph_addr;
        logic enable;
        logic closed_at_rest;
        logic sim_on;
        relay_fn_t func;
        logic [15:0] low_set;
        logic [15:0] high_set;
        logic [7:0] delay_set;
        logic [15:0] speed;
        logic [15:0] rate_gain;
        logic [15:0] saved_gain;
        serial_cfg_t serial;
        logic [24:0] tick_cnt;
        logic [15:0] delay_cnt;
        logic [7:0] hold_cnt;
        logic hold_done;
        logic program_mode;
        logic setting_step;
        logic alarm;
        logic lifter_on;
        span_step_t span;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic contact;
    } relay_state_t;

    function automatic logic [15:0] bcd4_to_bin(input logic [15:0] d);
        return 16'(d[15:12] * 16'd1000 + d[11:8] * 16'd100 +
                   d[7:4] * 16'd10 + d[3:0]);
    endfunction

endpackage
`default_nettype wire

//--- bench/lifter_model.sv
/*
 * Behavioural model of the calibration weight lifter that drives the
 * span cycle step code into the relay controller.
 * Assumes the bench calls step() from its main sequence.
 */
`timescale 1ns/100ps
`default_nettype none
module lifter_model (
    input wire logic sys_clk,
    output logic [1:0] span_step
);
    initial begin
        span_step = 2'h0;
    end

    // Holds each step long enough to cross the two-stage synchroniser
    task automatic step(input logic [1:0] code);
        @(posedge sys_clk);
        span_step <= code;
        repeat (8) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

//--- bench/test_speed_alarm_relay_control.sv
/*
 * Testbench for the speed alarm relay controller: AHB-Lite register
 * tasks and directed tests of alarms, lifter, button and serial setup.
 * Assumes the design package and the lifter model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module test_speed_alarm_relay_control;
    logic sys_clk, resetn, haddr_sel, hwrite, function_button;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, span_step, port_a_role, port_b_role;
    logic [2:0] hsize;
    logic hreadyout, hresp, relay_contact, program_mode, setting_step, irq;
    logic [3:0] station_id;
    logic [15:0] rate_gain;
    wire logic hready;
    int fails, num_checks, steps, n0;
    logic [31:0] ser [2] = '{32'hf6, 32'h09};

    assign hready = hreadyout;

    // Short tick keeps second-long delays to a few thousand cycles
    speed_alarm_relay_control #(.TICK_CYCLES(10)) i_dut (
        .sys_clk(sys_clk), .resetn(resetn), .haddr_sel(haddr_sel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .function_button(function_button), .span_step(span_step),
        .relay_contact(relay_contact), .program_mode(program_mode),
        .setting_step(setting_step), .station_id(station_id),
        .port_a_role(port_a_role), .port_b_role(port_b_role),
        .rate_gain(rate_gain), .irq(irq)
    );

    lifter_model i_lift (.sys_clk(sys_clk), .span_step(span_step));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (setting_step === 1'b1) steps <= steps + 1;
    end

    task automatic summarize;
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_pin(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: pin %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hready !== 1'b1 && n < 40);
        if (hready !== 1'b1) begin
            fails++;
            $display("ERROR at %0t: hready %h expected %h", $time, hready,
                     1'b1);
            summarize();
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        haddr_sel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready();
        haddr_sel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        check(q & m, e);
        check_pin(hresp, 1'b0);
    endtask

    // Contact must stay off v for lo cycles, then reach v within hi
    task automatic settle(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (relay_contact !== v && n < hi) begin
            @(posedge sys_clk);
            n++;
        end
        check_pin(relay_contact, v);
        if (relay_contact !== v) summarize();
        check_pin(n >= lo, 1'b1);
    endtask

    task automatic fn_case(input logic [2:0] fn, input logic pol,
                           input logic [15:0] ok, input logic [15:0] bad);
        wr(relay_ctl_pkg::OFS_SPEED, {16'h0, ok});
        wr(relay_ctl_pkg::OFS_CTRL, {25'h0, fn, 2'b00, pol, 1'b1});
        settle(pol, 0, 6);
        wr(relay_ctl_pkg::OFS_SPEED, {16'h0, bad});
        settle(~pol, 0, 6);
        wr(relay_ctl_pkg::OFS_SPEED, {16'h0, ok});
        settle(pol, 0, 6);
    endtask

    // Button held for cyc cycles, then released and allowed to settle
    task automatic press(input int cyc);
        @(posedge sys_clk);
        function_button <= 1'b1;
        repeat (cyc) @(posedge sys_clk);
        function_button <= 1'b0;
        repeat (20) @(posedge sys_clk);
    endtask

    initial begin
        resetn = 1'b0;
        haddr_sel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        function_button = 1'b0;
        fails = 0;
        num_checks = 0;
        steps = 0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);

        check_pin(relay_contact, 1'b0);
        rd_chk(relay_ctl_pkg::OFS_CTRL, 32'hffffffff, 32'h0);
        rd_chk(relay_ctl_pkg::OFS_LOW, 32'hffff, 32'h0015);
        rd_chk(relay_ctl_pkg::OFS_HIGH, 32'hffff, 32'h0100);
        rd_chk(relay_ctl_pkg::OFS_DELAY, 32'hff, 32'h00);
        rd_chk(8'h3c, 32'hffffffff, 32'h0);
        $display("test done: reset values");

        wr(relay_ctl_pkg::OFS_LOW, 32'h0015);
        wr(relay_ctl_pkg::OFS_HIGH, 32'h0100);
        fn_case(relay_ctl_pkg::FN_LOW_SPEED, 0, 16'h15, 16'h14);
        fn_case(relay_ctl_pkg::FN_LOW_SPEED, 1, 16'h15, 16'h14);
        fn_case(relay_ctl_pkg::FN_HIGH_SPEED, 0, 16'h100, 16'h101);
        fn_case(relay_ctl_pkg::FN_HIGH_SPEED, 1, 16'h99, 16'h101);
        fn_case(relay_ctl_pkg::FN_BAND_SPEED, 1, 16'h50, 16'h14);
        fn_case(relay_ctl_pkg::FN_BAND_SPEED, 0, 16'h100, 16'h101);
        $display("test done: alarm functions");

        wr(relay_ctl_pkg::OFS_SPEED, 32'h14);
        wr(relay_ctl_pkg::OFS_CTRL, 32'h10);
        repeat (20) @(posedge sys_clk);
        check_pin(relay_contact, 1'b0);
        wr(relay_ctl_pkg::OFS_CTRL, 32'h01);
        repeat (20) @(posedge sys_clk);
        check_pin(relay_contact, 1'b0);
        $display("test done: enable");

        // Shared delay of 39 s is 3900 cycles at the shortened tick
        wr(relay_ctl_pkg::OFS_SPEED, 32'h50);
        wr(relay_ctl_pkg::OFS_DELAY, 32'h39);
        wr(relay_ctl_pkg::OFS_CTRL, 32'h31);
        wr(relay_ctl_pkg::OFS_SPEED, 32'h14);
        settle(1'b1, 3800, 4000);
        wr(relay_ctl_pkg::OFS_SPEED, 32'h50);
        settle(1'b0, 0, 6);
        wr(relay_ctl_pkg::OFS_SPEED, 32'h101);
        repeat (2000) @(posedge sys_clk);
        wr(relay_ctl_pkg::OFS_SPEED, 32'h50);
        repeat (20) @(posedge sys_clk);
        check_pin(relay_contact, 1'b0);
        wr(relay_ctl_pkg::OFS_SPEED, 32'h101);
        settle(1'b1, 3800, 4000);
        $display("test done: operate delay");

        wr(relay_ctl_pkg::OFS_SPEED, 32'h50);
        wr(relay_ctl_pkg::OFS_DELAY, 32'h00);
        wr(relay_ctl_pkg::OFS_CTRL, 32'h11);
        wr(relay_ctl_pkg::OFS_IRQ_MASK, 32'h0);
        rd_chk(relay_ctl_pkg::OFS_IRQ_STAT, 32'h7, 32'h3);
        wr(relay_ctl_pkg::OFS_SPEED, 32'h14);
        settle(1'b1, 0, 6);
        check_pin(irq, 1'b0);
        wr(relay_ctl_pkg::OFS_IRQ_MASK, 32'h1);
        repeat (3) @(posedge sys_clk);
        check_pin(irq, 1'b1);
        rd_chk(relay_ctl_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
        repeat (3) @(posedge sys_clk);
        check_pin(irq, 1'b0);
        rd_chk(relay_ctl_pkg::OFS_IRQ_STAT, 32'h7, 32'h0);
        wr(relay_ctl_pkg::OFS_SPEED, 32'h50);
        $display("test done: interrupt");

        for (int p = 0; p < 2; p++) begin
            wr(relay_ctl_pkg::OFS_CTRL, {25'h0, 3'h4, 2'b00, p[0], 1'b1});
            settle(p[0], 0, 6);
            i_lift.step(2'h1);
            check_pin(relay_contact, ~p[0]);
            i_lift.step(2'h3);
            check_pin(relay_contact, ~p[0]);
            i_lift.step(2'h2);
            check_pin(relay_contact, p[0]);
            i_lift.step(2'h0);
            check_pin(relay_contact, p[0]);
        end
        $display("test done: weight lifter");

        foreach (ser[i]) begin
            wr(relay_ctl_pkg::OFS_SERIAL, ser[i]);
            repeat (2) @(posedge sys_clk);
            check({24'h0, station_id, port_a_role, port_b_role},
                  ser[i]);
        end
        $display("test done: serial setup");

        wr(relay_ctl_pkg::OFS_GAIN, 32'h1234);
        rd_chk(relay_ctl_pkg::OFS_IRQ_STAT, 32'h7, 32'h2);
        press(300);
        check_pin(program_mode, 1'b0);
        press(560);
        check_pin(program_mode, 1'b1);
        rd_chk(relay_ctl_pkg::OFS_IRQ_STAT, 32'h4, 32'h4);
        n0 = steps;
        press(300);
        check(32'(steps - n0), 32'h1);
        check_pin(program_mode, 1'b1);
        wr(relay_ctl_pkg::OFS_CTRL, 32'h4);
        wr(relay_ctl_pkg::OFS_GAIN, 32'h5678);
        repeat (2) @(posedge sys_clk);
        check({16'h0, rate_gain}, 32'h5678);
        press(560);
        check_pin(program_mode, 1'b0);
        check({16'h0, rate_gain}, 32'h1234);
        rd_chk(relay_ctl_pkg::OFS_CTRL, 32'h4, 32'h0);
        $display("test done: mode button");
        summarize();
    end
endmodule
`default_nettype wire
